// ===== design/charger_regs_consts.svh
// register offsets, field positions, reset values and a timing count
// assumes an 8-bit register port with a byte address from the serial front end
`ifndef CHARGER_REGS_CONSTS_SVH
`define CHARGER_REGS_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_OUTPUT_LEVEL  8'h00
`define OFS_FREQ_GAIN     8'h01
`define OFS_CUR_LIMIT     8'h02
`define OFS_RETRY_CHARGE  8'h03
`define OFS_CFG_COMPLETE  8'h04
`define OFS_SAMPLE_REQ    8'h05
`define OFS_EVENT_MASK    8'h07
`define OFS_BUS_MASK      8'h08
`define OFS_INPUT_MASK    8'h09
`define OFS_EVENT_FLAGS   8'h0A
`define OFS_BUS_FLAGS     8'h0B
`define OFS_INPUT_FLAGS   8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_CONV_ON       5
`define BIT_SYNC_DIR      1
`define BIT_SPREAD        0
`define BIT_TRIP          4
`define BIT_AUTO_CLEAR    7
`define BIT_UNCONFIGURED  7
`define BIT_ATTACH_SEEN   3
`define BIT_ATTACH_CHANGE 1
`define BIT_MEAS_DONE     0
`define BIT_LIMIT_LOW     5
`define BIT_CUR_LIMIT     4

// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define WMASK_OUTPUT      8'h3F
`define WMASK_FREQ_GAIN   8'hFF
`define WMASK_CUR_LIMIT   8'h17
`define WMASK_RETRY       8'hF0
`define WMASK_EVENT       8'h8B
`define WMASK_BUS         8'h3F
`define WMASK_INPUT       8'h0E
`define RST_OUTPUT_LEVEL  8'h20
`define RST_FREQ_GAIN     8'h00
`define RST_CUR_LIMIT     8'h07
`define RST_MASK          8'h00
`define LEVEL_DEFAULT     3'h0
`define LEVEL_PASS        3'h4

// ----------------------------------------
// timing
// ----------------------------------------
`define SAMPLE_TIME_NS    1000
`define CLK_PERIOD_NS     25
`define SAMPLE_CYCLES     ((`SAMPLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== design/charger_regs_pkg.sv
// types shared by the charger setup and flag register bank
// assumes the consts header is included by the files that need numbers
`default_nettype none
package charger_regs_pkg;
  // register port request from the serial front end
  typedef struct packed {
    logic       wr;    // write strobe, one cycle
    logic       rd;    // read strobe, one cycle
    logic [7:0] addr;  // register offset
    logic [7:0] wdata; // write data
  } reg_req_s;
  // raw conditions from the analog side
  typedef struct packed {
    logic limit_low;  // current limit with undervoltage
    logic cur_limit;  // current limit
    logic bus_ov;     // bus overvoltage
    logic bus_uv;     // bus undervoltage
    logic bus_short;  // short to ground
    logic overtemp;   // overtemperature
    logic therm_warn; // thermal warning
    logic input_overvolt_flag;      // input overvoltage
    logic datapin_overvolt_flag;    // data pin overvoltage
    logic attached;   // charge detect sees a device
  } cond_s;
  // converter setup outputs
  typedef struct packed {
    logic [2:0] output_level_sel;
    logic       sync_is_input;
    logic       spread_en;
    logic [2:0] switch_freq_sel;
    logic [4:0] drop_gain;
    logic       trip_behaviour;
    logic [2:0] current_limit_sel;
    logic [1:0] retry_delay_sel;
    logic [1:0] charge_detect_mode;
  } setup_s;
  // sampler state
  typedef enum logic [0:0] {SAMP_IDLE, SAMP_BUSY} samp_e;
endpackage : charger_regs_pkg
`default_nettype wire

// ===== design/usb_charger_setup_irq_regs.sv
// setup and interrupt flag register bank of a usb charger converter
// assumes a serial front end gives one-cycle rd/wr strobes on this clock
// Summary of operation
// - output level decodes 0 default, 4 pass-through
// - bit 1 sync direction, strap preloaded
// - bit 0 spread spectrum, strap preloaded
// - frequency field bits 7:5, resets zero
// - five-bit cable gain, resets zero
// - trip bit selects combined or plain fault
// - current limit bits 2:0, resets seven
// - retry delay bits 7:6, resets zero
// - charge detect mode preloaded from straps
// - converter held off until configured
// - sample request bit self-clears when done
// - measurement done flag, clear on read
// - auto-clear bit chooses latched or live flags
// - mask bits admit flags to interrupt
// - unconfigured flag reads one until configured
// - attach change flag ignores auto-clear
// - attach seen flag on attachment
// - fault flags clear on read if resolved
// - trip bit suppresses one of two limit flags
// - converter enable ands with external pin
// - third register faults clear if resolved
// - read of flag register drops interrupt
`default_nettype none
`include "charger_regs_consts.svh"

module usb_charger_setup_irq_regs #(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES  // sample duration in clocks
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // register port
  input  wire charger_regs_pkg::reg_req_s req,
  output var  logic [7:0]                 rdata,
  // straps and pins
  input  wire logic                       strap_sync_dir,
  input  wire logic                       strap_spread,
  input  wire logic [1:0]                 strap_charge_mode,
  input  wire logic                       ext_enable_pin,
  // analog side
  input  wire charger_regs_pkg::cond_s    cond,
  input  wire logic                       sample_done,
  // outputs
  output var  charger_regs_pkg::setup_s   setup,
  output var  logic                       converter_on,
  output var  logic                       sample_start,
  output var  logic                       irq
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (SAMPLE_CYCLES < 1) begin : g_chk
    $error("SAMPLE_CYCLES must be at least one");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [13:0] sync1_q;  // first stage, read only by second
  logic [13:0] sync2_q;  // settled copy
  logic [13:0] raw_in;   // async inputs together except the charge mode strap
  assign raw_in = {cond, ext_enable_pin, strap_sync_dir, strap_spread, sample_done};
  // two flops on every pin input
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_q <= 14'h0000;
      sync2_q <= 14'h0000;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end
  charger_regs_pkg::cond_s c;  // settled conditions
  logic pin_en_s;             // settled external enable
  logic s_sync_dir;           // settled sync strap
  logic s_spread;             // settled spread strap
  logic done_s;               // settled sample finish
  assign {c, pin_en_s, s_sync_dir, s_spread, done_s} = sync2_q;
  logic [1:0] mode_s1_q;      // charge mode strap first stage
  logic [1:0] mode_s2_q;      // charge mode strap second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
    end else begin
      mode_s1_q <= strap_charge_mode;
      mode_s2_q <= mode_s1_q;
    end
  end

  // ----------------------------------------
  // strap capture after reset release
  // ----------------------------------------
  // straps are caught a few clocks after release, once the sync chain is full
  logic [1:0] strap_cnt_q;  // settling counter
  logic       strap_ld;     // one-cycle load of strap values
  always_ff @(posedge clock) begin
    if (rst) begin
      strap_cnt_q <= 2'h0;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end
  assign strap_ld = (strap_cnt_q == 2'h2);

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic wr;  // write strobe
  logic rd;  // read strobe
  assign wr = req.wr;
  assign rd = req.rd;
  function automatic logic hit(input logic [7:0] ofs);
    hit = (req.addr == ofs);
  endfunction

  // ----------------------------------------
  // setup registers
  // ----------------------------------------
  logic [7:0] out_lvl_q;  // level, sync dir, spread, converter enable
  logic [7:0] freq_q;     // frequency and cable gain
  logic [7:0] current_limit_sel_q;     // trip behaviour and current limit
  logic [7:0] retry_q;    // retry delay and charge mode
  logic       cfg_q;      // configuration complete
  // reserved bits masked on every write
  always_ff @(posedge clock) begin
    if (rst) begin
      out_lvl_q <= `RST_OUTPUT_LEVEL;
      freq_q    <= `RST_FREQ_GAIN;
      current_limit_sel_q    <= `RST_CUR_LIMIT;
      retry_q   <= 8'h00;
    end else if (strap_ld) begin
      out_lvl_q[`BIT_SYNC_DIR] <= s_sync_dir;
      out_lvl_q[`BIT_SPREAD]   <= s_spread;
      retry_q[5:4]             <= mode_s2_q;
    end else if (wr) begin
      if (hit(`OFS_OUTPUT_LEVEL)) out_lvl_q <= req.wdata & `WMASK_OUTPUT;
      if (hit(`OFS_FREQ_GAIN))    freq_q    <= req.wdata & `WMASK_FREQ_GAIN;
      if (hit(`OFS_CUR_LIMIT))    current_limit_sel_q    <= req.wdata & `WMASK_CUR_LIMIT;
      if (hit(`OFS_RETRY_CHARGE)) retry_q   <= req.wdata & `WMASK_RETRY;
    end
  end
  // configured bit, once set stays until reset
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q <= 1'b0;
    end else if (wr && hit(`OFS_CFG_COMPLETE) && req.wdata[0]) begin
      cfg_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // decoded setup outputs
  // ----------------------------------------
  // unused level codes fold onto the default level
  always_ff @(posedge clock) begin
    if (rst) begin
      setup <= '0;
    end else begin
      setup.output_level_sel   <= (out_lvl_q[4:2] > `LEVEL_PASS) ? `LEVEL_DEFAULT
                                                                 : out_lvl_q[4:2];
      setup.sync_is_input      <= out_lvl_q[`BIT_SYNC_DIR];
      setup.spread_en          <= out_lvl_q[`BIT_SPREAD];
      setup.switch_freq_sel    <= freq_q[7:5];
      setup.drop_gain          <= freq_q[4:0];
      setup.trip_behaviour     <= current_limit_sel_q[`BIT_TRIP];
      setup.current_limit_sel  <= current_limit_sel_q[2:0];
      setup.retry_delay_sel    <= retry_q[7:6];
      setup.charge_detect_mode <= retry_q[5:4];
    end
  end
  // converter runs only when configured, enabled and pin high
  always_ff @(posedge clock) begin
    if (rst) begin
      converter_on <= 1'b0;
    end else begin
      converter_on <= cfg_q && out_lvl_q[`BIT_CONV_ON] && pin_en_s;
    end
  end

  // ----------------------------------------
  // sample request
  // ----------------------------------------
  charger_regs_pkg::samp_e samp_q;  // sampler state
  logic        req_bit_q;            // readable request bit
  logic        meas_evt;             // one-cycle results ready
  logic [31:0] samp_cnt_q;           // fallback timeout count
  // finishes on the done input or after the sample time
  always_ff @(posedge clock) begin
    if (rst) begin
      samp_q     <= charger_regs_pkg::SAMP_IDLE;
      req_bit_q  <= 1'b0;
      samp_cnt_q <= 32'h0;
    end else begin
      case (samp_q)
        charger_regs_pkg::SAMP_IDLE: begin
          if (wr && hit(`OFS_SAMPLE_REQ) && req.wdata[0]) begin
            samp_q     <= charger_regs_pkg::SAMP_BUSY;
            req_bit_q  <= 1'b1;
            samp_cnt_q <= 32'h0;
          end
        end
        charger_regs_pkg::SAMP_BUSY: begin
          samp_cnt_q <= samp_cnt_q + 32'h1;
          if (done_s || samp_cnt_q >= 32'(SAMPLE_CYCLES - 1)) begin
            samp_q    <= charger_regs_pkg::SAMP_IDLE;
            req_bit_q <= 1'b0;
          end
        end
        default: samp_q <= charger_regs_pkg::SAMP_IDLE;
      endcase
    end
  end
  assign meas_evt = (samp_q == charger_regs_pkg::SAMP_BUSY) &&
                    (done_s || samp_cnt_q >= 32'(SAMPLE_CYCLES - 1));
  // start pulse to the converter of the analog side
  always_ff @(posedge clock) begin
    if (rst) begin
      sample_start <= 1'b0;
    end else begin
      sample_start <= (samp_q == charger_regs_pkg::SAMP_IDLE) && wr &&
                      hit(`OFS_SAMPLE_REQ) && req.wdata[0];
    end
  end

  // ----------------------------------------
  // mask registers
  // ----------------------------------------
  logic [7:0] ev_mask_q;   // event mask and auto clear
  logic [7:0] bus_mask_q;  // bus fault mask
  logic [7:0] in_mask_q;   // input fault mask
  always_ff @(posedge clock) begin
    if (rst) begin
      ev_mask_q  <= `RST_MASK;
      bus_mask_q <= `RST_MASK;
      in_mask_q  <= `RST_MASK;
    end else if (wr) begin
      if (hit(`OFS_EVENT_MASK)) ev_mask_q  <= req.wdata & `WMASK_EVENT;
      if (hit(`OFS_BUS_MASK))   bus_mask_q <= req.wdata & `WMASK_BUS;
      if (hit(`OFS_INPUT_MASK)) in_mask_q  <= req.wdata & `WMASK_INPUT;
    end
  end
  logic auto_clr;  // live flags instead of latched
  assign auto_clr = ev_mask_q[`BIT_AUTO_CLEAR];

  // ----------------------------------------
  // flag sources
  // ----------------------------------------
  logic attached_q;  // previous attach state
  always_ff @(posedge clock) begin
    if (rst) begin
      attached_q <= 1'b0;
    end else begin
      attached_q <= c.attached;
    end
  end
  logic [7:0] ev_set;   // event set terms
  logic [7:0] ev_live;  // event conditions still present
  logic [7:0] bus_set;  // bus fault conditions
  logic [7:0] in_set;   // input fault conditions
  logic       trip;     // trip behaviour bit
  assign trip    = current_limit_sel_q[`BIT_TRIP];
  assign ev_set  = {4'h0, c.attached, 1'b0, c.attached ^ attached_q, meas_evt};
  assign ev_live = {4'h0, c.attached, 3'h0};
  assign bus_set = {2'h0, c.limit_low & ~trip, c.cur_limit & trip, c.bus_ov,
                    c.bus_uv, c.bus_short, c.overtemp};
  assign in_set  = {4'h0, c.therm_warn, c.input_overvolt_flag, c.datapin_overvolt_flag, 1'b0};

  // ----------------------------------------
  // flag registers
  // ----------------------------------------
  logic [7:0] ev_q;   // event flags
  logic [7:0] bus_q;  // bus fault flags
  logic [7:0] in_q;   // input fault flags
  logic rd_ev;        // read of event flags
  logic rd_bus;       // read of bus flags
  logic rd_in;        // read of input flags
  assign rd_ev  = rd && hit(`OFS_EVENT_FLAGS);
  assign rd_bus = rd && hit(`OFS_BUS_FLAGS);
  assign rd_in  = rd && hit(`OFS_INPUT_FLAGS);
  // set wins over clear; faults still present survive a read
  always_ff @(posedge clock) begin
    if (rst) begin
      ev_q  <= 8'h00;
      bus_q <= 8'h00;
      in_q  <= 8'h00;
    end else begin
      // change and done flags ignore auto clear
      ev_q  <= ev_set | (ev_q & ~({8{rd_ev}} |
               ({8{auto_clr}} & ~ev_live & (8'h01 << `BIT_ATTACH_SEEN))));
      bus_q <= bus_set | (bus_q & ~({8{rd_bus}} | {8{auto_clr}}));
      in_q  <= in_set  | (in_q  & ~({8{rd_in}}  | {8{auto_clr}}));
    end
  end
  logic [7:0] ev_view;  // event flags with unconfigured bit
  assign ev_view = ev_q | ({7'h00, ~cfg_q} << `BIT_UNCONFIGURED);

  // ----------------------------------------
  // interrupt and read data
  // ----------------------------------------
  // read pulls the line for one cycle so a persistent fault re-asserts it
  logic [7:0] ev_pend;  // masked pending events
  assign ev_pend = ev_view & ev_mask_q & `WMASK_EVENT & 8'h7F;
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (|ev_pend && !rd_ev) || (|(bus_q & bus_mask_q) && !rd_bus) ||
             (|(in_q & in_mask_q) && !rd_in);
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (req.addr)
        `OFS_OUTPUT_LEVEL: rdata <= out_lvl_q;
        `OFS_FREQ_GAIN:    rdata <= freq_q;
        `OFS_CUR_LIMIT:    rdata <= current_limit_sel_q;
        `OFS_RETRY_CHARGE: rdata <= retry_q;
        `OFS_CFG_COMPLETE: rdata <= {7'h00, cfg_q};
        `OFS_SAMPLE_REQ:   rdata <= {7'h00, req_bit_q};
        `OFS_EVENT_MASK:   rdata <= ev_mask_q;
        `OFS_BUS_MASK:     rdata <= bus_mask_q;
        `OFS_INPUT_MASK:   rdata <= in_mask_q;
        `OFS_EVENT_FLAGS:  rdata <= ev_view;
        `OFS_BUS_FLAGS:    rdata <= bus_q;
        `OFS_INPUT_FLAGS:  rdata <= in_q;
        default:           rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_conv_gated: assert property (@(posedge clock) disable iff (rst)
    !cfg_q |=> !converter_on) else $error("converter on before configured");
  a_level_fold: assert property (@(posedge clock) disable iff (rst)
    out_lvl_q[4:2] > 3'h4 |=> setup.output_level_sel == 3'h0)
    else $error("level not folded");
  a_req_clears: assert property (@(posedge clock) disable iff (rst)
    samp_q == charger_regs_pkg::SAMP_BUSY && done_s |=> !req_bit_q)
    else $error("request stuck");
  a_done_sets: assert property (@(posedge clock) disable iff (rst)
    meas_evt |=> ev_q[0]) else $error("done flag lost");
  // checks the read path, not just the view expression
  a_unconfig_bit: assert property (@(posedge clock) disable iff (rst)
    rd_ev |=> rdata[7] == !$past(cfg_q)) else $error("unconfigured bit wrong");
  a_limit_supp: assert property (@(posedge clock) disable iff (rst)
    !trip && !bus_q[4] |=> !bus_q[4]) else $error("limit flag leaked");
  a_fault_keep: assert property (@(posedge clock) disable iff (rst)
    rd_bus && c.overtemp |=> bus_q[0]) else $error("live fault cleared");
  a_read_drops: assert property (@(posedge clock) disable iff (rst)
    rd_bus && ev_pend == 8'h00 && (in_q & in_mask_q) == 8'h00 |=> !irq)
    else $error("irq held through read");
  a_mask_gate: assert property (@(posedge clock) disable iff (rst)
    ev_mask_q == 8'h00 && bus_mask_q == 8'h00 && in_mask_q == 8'h00 |=> !irq)
    else $error("masked irq");
  c_sample: cover property (@(posedge clock) disable iff (rst) sample_start ##[1:60] meas_evt);
  c_fault_irq: cover property (@(posedge clock) disable iff (rst) irq && bus_q != 8'h00);
  c_configure: cover property (@(posedge clock) disable iff (rst) $rose(cfg_q));

endmodule : usb_charger_setup_irq_regs
`default_nettype wire

// ===== dv/analog_side_model.sv
// behavioural stand-in for the analog sampler behind the register bank
// assumes sample_start is a one-cycle pulse on the same clock
`default_nettype none
module analog_side_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // sampler handshake
  input  wire logic       sample_start,
  input  wire logic [7:0] done_delay,  // cycles before the answer, set by the bench
  output var  logic       sample_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // sampler timing
  // ----------------------------------------
  logic [7:0] count_q;  // cycles left until the answer
  logic       busy_q;   // a conversion is running
  logic       done_q;   // one-cycle completion pulse
  // a long delay lets the bench see the design's own time limit end a sample
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_q  <= 1'h0;
      count_q <= 8'h00;
      done_q  <= 1'h0;
    end else begin
      done_q <= 1'h0;
      if (sample_start) begin
        busy_q  <= 1'h1;
        count_q <= done_delay;
      end else if (busy_q && count_q == 8'h00) begin
        busy_q <= 1'h0;
        done_q <= 1'h1;
      end else if (busy_q) begin
        count_q <= count_q - 8'h01;
      end
    end
  end
  assign sample_done = done_q;
endmodule // analog_side_model
`default_nettype wire

// ===== dv/usb_charger_setup_irq_regs_test.sv
// self-checking bench for the charger setup and flag register bank
// assumes the analog sampler model and the design's consts header
`default_nettype none
`include "charger_regs_consts.svh"
module usb_charger_setup_irq_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic                       clock;
  logic                       rst;
  charger_regs_pkg::reg_req_s req;
  logic [7:0]                 rdata;
  logic                       ext_enable_pin;
  charger_regs_pkg::cond_s    cond;
  logic                       sample_done;
  charger_regs_pkg::setup_s   setup;
  logic                       converter_on;
  logic                       sample_start;
  logic                       irq;
  logic [7:0]                 done_delay;
  logic [3:0]                 straps;  // sync dir, spread, charge mode
  int                         n_errors;
  int                         checks_done;
  // straps start as sync input, spread off, charge mode 01
  // limit of 8 lets a prompt answer end a sample before the timeout
  usb_charger_setup_irq_regs #(.SAMPLE_CYCLES(8)) i_dut (
    .clock(clock), .rst(rst), .req(req), .rdata(rdata), .strap_sync_dir(straps[3]),
    .strap_spread(straps[2]), .strap_charge_mode(straps[1:0]), .ext_enable_pin(ext_enable_pin),
    .cond(cond), .sample_done(sample_done), .setup(setup), .converter_on(converter_on),
    .sample_start(sample_start), .irq(irq));
  analog_side_model i_model (
    .clock(clock), .rst(rst), .sample_start(sample_start), .done_delay(done_delay),
    .sample_done(sample_done));
  // 40 MHz clock
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t: byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t: bit %b expected %b", $time, g, e);
    end
  endtask
  task automatic cmp_setup(input charger_regs_pkg::setup_s e);
    checks_done++;
    if (setup !== e) begin
      n_errors++;
      $display("ERROR %0t: setup %h expected %h", $time, setup, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  // inputs change 2 ns after the edge; strobes last one cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #2;
    req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clock);
    #2;
    req.wr = 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    #2;
    req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clock);
    #2;
    req.rd = 1'h0;
    cmp8(rdata, e);
  endtask
  // ----------------------------------------
  // tables: reset image and writable masks
  // ----------------------------------------
  localparam logic [7:0] RST_A[13] = '{`OFS_OUTPUT_LEVEL, `OFS_FREQ_GAIN, `OFS_CUR_LIMIT,
    `OFS_RETRY_CHARGE, `OFS_CFG_COMPLETE, `OFS_SAMPLE_REQ, `OFS_EVENT_MASK, `OFS_BUS_MASK,
    `OFS_INPUT_MASK, `OFS_EVENT_FLAGS, `OFS_BUS_FLAGS, `OFS_INPUT_FLAGS, 8'h06};
  localparam logic [7:0] RST_E[13] = '{8'h22, 8'h00, 8'h07, 8'h10, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RW_A[7] = '{`OFS_OUTPUT_LEVEL, `OFS_FREQ_GAIN, `OFS_CUR_LIMIT,
    `OFS_RETRY_CHARGE, `OFS_EVENT_MASK, `OFS_BUS_MASK, `OFS_INPUT_MASK};
  localparam logic [7:0] RW_E[7] = '{`WMASK_OUTPUT, `WMASK_FREQ_GAIN, `WMASK_CUR_LIMIT,
    `WMASK_RETRY, `WMASK_EVENT, `WMASK_BUS, `WMASK_INPUT};
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_errors = 0;
    checks_done = 0;
    rst = 1'h1;
    req = '0;
    cond = '0;
    ext_enable_pin = 1'h1;
    done_delay = 8'h01;
    straps = 4'h9;
    idle(10);
    rst = 1'h0;
    idle(5);
    // reset image, straps, unmapped offset
    for (int i = 0; i < 13; i++) rd_chk(RST_A[i], RST_E[i]);
    cmp_setup('{`LEVEL_DEFAULT, 1'h1, 1'h0, 3'h0, 5'h00, 1'h0, 3'h7, 2'h0, 2'h1});
    // all ones: reserved bits stay zero, fields reach the setup outputs
    for (int i = 0; i < 7; i++) wr_reg(RW_A[i], 8'hFF);
    for (int i = 0; i < 7; i++) rd_chk(RW_A[i], RW_E[i]);
    cmp_setup('{`LEVEL_DEFAULT, 1'h1, 1'h1, 3'h7, 5'h1F, 1'h1, 3'h7, 2'h3, 2'h3});
    wr_reg(`OFS_OUTPUT_LEVEL, 8'h30);
    idle(1);
    cmp8({5'h00, setup.output_level_sel}, {5'h00, `LEVEL_PASS});
    wr_reg(`OFS_EVENT_MASK, 8'h00);
    wr_reg(`OFS_BUS_MASK, 8'h00);
    wr_reg(`OFS_INPUT_MASK, 8'h00);
    // converter held off until configured, then gated by the pin
    cmp1(converter_on, 1'h0);
    wr_reg(`OFS_CFG_COMPLETE, 8'h01);
    idle(4);
    cmp1(converter_on, 1'h1);
    rd_chk(`OFS_EVENT_FLAGS, 8'h00);
    wr_reg(`OFS_CFG_COMPLETE, 8'h00);
    rd_chk(`OFS_CFG_COMPLETE, 8'h01);
    ext_enable_pin = 1'h0;
    idle(4);
    cmp1(converter_on, 1'h0);
    ext_enable_pin = 1'h1;
    // samples answered promptly, then past the design's own limit
    for (int d = 0; d < 2; d++) begin
      done_delay = (d == 0) ? 8'h01 : 8'h14;
      wr_reg(`OFS_SAMPLE_REQ, 8'h01);
      cmp1(sample_start, 1'h1);
      repeat (3) rd_chk(`OFS_SAMPLE_REQ, 8'h01);
      // a prompt answer ends the sample before the design's own limit
      rd_chk(`OFS_SAMPLE_REQ, (d == 0) ? 8'h00 : 8'h01);
      idle(30);
      rd_chk(`OFS_SAMPLE_REQ, 8'h00);
      rd_chk(`OFS_EVENT_FLAGS, 8'h01);
      rd_chk(`OFS_EVENT_FLAGS, 8'h00);
    end
    // a masked fault raises irq; a read drops it while the fault persists
    wr_reg(`OFS_BUS_MASK, 8'h08);
    cond.bus_ov = 1'h1;
    idle(6);
    cmp1(irq, 1'h1);
    rd_chk(`OFS_BUS_FLAGS, 8'h08);
    cmp1(irq, 1'h0);
    idle(2);
    cmp1(irq, 1'h1);
    rd_chk(`OFS_BUS_FLAGS, 8'h08);
    cond.bus_ov = 1'h0;
    cond.overtemp = 1'h1;
    idle(6);
    rd_chk(`OFS_BUS_FLAGS, 8'h09);
    cond.overtemp = 1'h0;
    idle(6);
    rd_chk(`OFS_BUS_FLAGS, 8'h01);
    cmp1(irq, 1'h0);
    rd_chk(`OFS_BUS_FLAGS, 8'h00);
    // trip bit picks which limit flag counts
    for (int t = 1; t >= 0; t--) begin
      wr_reg(`OFS_CUR_LIMIT, (t == 1) ? 8'h17 : 8'h07);
      cond.cur_limit = 1'h1;
      cond.limit_low = 1'h1;
      idle(6);
      rd_chk(`OFS_BUS_FLAGS, (t == 1) ? 8'h10 : 8'h20);
      cond.cur_limit = 1'h0;
      cond.limit_low = 1'h0;
      idle(6);
      rd_chk(`OFS_BUS_FLAGS, (t == 1) ? 8'h10 : 8'h20);
      rd_chk(`OFS_BUS_FLAGS, 8'h00);
    end
    // auto clear against latched input faults
    for (int ac = 1; ac >= 0; ac--) begin
      wr_reg(`OFS_EVENT_MASK, (ac == 1) ? 8'h80 : 8'h00);
      cond.input_overvolt_flag = 1'h1;
      idle(6);
      cond.input_overvolt_flag = 1'h0;
      idle(6);
      rd_chk(`OFS_INPUT_FLAGS, (ac == 1) ? 8'h00 : 8'h04);
      rd_chk(`OFS_INPUT_FLAGS, 8'h00);
    end
    // attach: change flag ignores auto clear, seen flag follows the level
    wr_reg(`OFS_EVENT_MASK, 8'h80);
    cond.attached = 1'h1;
    idle(6);
    rd_chk(`OFS_EVENT_FLAGS, 8'h0A);
    rd_chk(`OFS_EVENT_FLAGS, 8'h08);
    cond.attached = 1'h0;
    idle(6);
    rd_chk(`OFS_EVENT_FLAGS, 8'h02);
    rd_chk(`OFS_EVENT_FLAGS, 8'h00);
    // mid-run reset with other straps: straps reload, configuration forgotten
    straps = 4'h6;
    rst = 1'h1;
    idle(2);
    rst = 1'h0;
    idle(5);
    cmp1(converter_on, 1'h0);
    rd_chk(`OFS_OUTPUT_LEVEL, 8'h21);
    rd_chk(`OFS_RETRY_CHARGE, 8'h20);
    rd_chk(`OFS_EVENT_FLAGS, 8'h80);
    cmp_setup('{`LEVEL_DEFAULT, 1'h0, 1'h1, 3'h0, 5'h00, 1'h0, 3'h7, 2'h0, 2'h2});
    report_and_stop();
  end
endmodule // usb_charger_setup_irq_regs_test
`default_nettype wire
